// file: hdl/crf_pkg.sv
// Overview of operation
// - Thirty-two working registers, eight bits each, apart from data memory.
// - Register reads and writes complete within one clock cycle.
// - Immediate-operand instructions reach only entries 16 to 31.
// - Entries 26 to 31 pair into three 16-bit address pointers.
// - The third pointer, entries 30 and 31, also addresses program memory.
// - Lower entry of a pair is the low byte, higher entry the high byte.
// - Pointers support displacement, post-increment and pre-decrement addressing.
// - The 16-bit stack pointer is the only register that reaches the byte bus through the shared staging byte.
// - Writing the low byte address only loads the staging byte.
// - Writing the high byte loads it and copies staging into the low byte together.
// - Reading the low byte captures the high byte into staging in that cycle.
// - Reading the high byte address returns the staging byte.
// - Protected writes and self-programming need a prior valid signature write.
// - Two unlock modes, protected I/O and self-programming, each with its signature.
// - I/O window closes on any memory write, nonvolatile access or sleep.
// - Self-programming window closes on any nonvolatile access or sleep.
// - No interrupt is taken while a window is open; requests stay pending.
// - After the window, all pending requests are serviced normally.
// - Signature 0xD8 unlocks I/O, 0x9D self-programming; others open nothing.
// - Guard bit 0 shows I/O unlock, bit 1 self-programming, bits 7:2 zero.
package crf_pkg;
    localparam int unsigned RF_DEPTH = 32;
    localparam int unsigned RF_WIDTH = 8;
    localparam logic [4:0] PTR_BASE = 5'h1A;
    localparam logic [5:0] GUARD_OFS = 6'h04;
    localparam logic [5:0] SP_LOW_OFS = 6'h0D;
    localparam logic [5:0] SP_HIGH_OFS = 6'h0E;
    localparam logic [5:0] STATUS_OFS = 6'h0F;
    localparam logic [7:0] SIG_IO = 8'hD8;
    localparam logic [7:0] SIG_SPM = 8'h9D;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'hFFFF;
    localparam logic [2:0] WINDOW_INSTRS = 3'h4;

    typedef enum logic [1:0] {
        PTR_NONE = 2'b00,
        PTR_DISP = 2'b01,
        PTR_POSTINC = 2'b10,
        PTR_PREDEC = 2'b11
    } crf_ptr_mode_t;

    typedef enum logic [1:0] {
        GUARD_OFF = 2'b00,
        GUARD_IO = 2'b01,
        GUARD_SPM = 2'b10
    } crf_guard_t;

    typedef struct packed {
        logic [1:0] sel;
        crf_ptr_mode_t mode;
        logic [5:0] disp;
    } crf_ptr_req_t;

    typedef struct packed {
        logic instr_done;
        logic mem_write;
        logic nvm_access;
        logic sleep;
    } crf_cpu_evt_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } crf_bus_req_t;
endpackage : crf_pkg

// file: hdl/crf_core.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ns
module crf_core #(
    parameter int unsigned IRQ_W = 8,
    parameter logic [15:0] SP_RESET = crf_pkg::SP_RESET
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [4:0] i_rf_raddr_a,
    input wire logic [4:0] i_rf_raddr_b,
    output logic [7:0] o_rf_rdata_a,
    output logic [7:0] o_rf_rdata_b,
    input wire logic i_rf_we,
    input wire logic i_rf_imm,
    input wire logic [4:0] i_rf_waddr,
    input wire logic [7:0] i_rf_wdata,
    input wire crf_pkg::crf_ptr_req_t i_ptr_req,
    output logic [15:0] o_ptr_addr,
    output logic [15:0] o_prog_ptr,
    input wire crf_pkg::crf_bus_req_t i_bus,
    output logic [7:0] o_reg_rdata,
    input wire crf_pkg::crf_cpu_evt_t i_evt,
    output logic o_io_unlocked,
    output logic o_spm_unlocked,
    input wire logic [IRQ_W-1:0] i_irq_req,
    input wire logic [IRQ_W-1:0] i_irq_ack,
    output logic [IRQ_W-1:0] o_irq_pending,
    output logic o_irq_take,
    output logic [15:0] o_stack_ptr,
    output logic [7:0] o_status
);

    typedef struct packed {
        logic [crf_pkg::RF_DEPTH-1:0][crf_pkg::RF_WIDTH-1:0] rf;
        logic [7:0] staging;
        logic [15:0] sp;
        logic [7:0] status_flags;
        crf_pkg::crf_guard_t guard;
        logic [2:0] cnt;
        logic [7:0] rdata;
        logic [IRQ_W-1:0] pend;
    } crf_state_t;

    localparam crf_state_t ST_RESET = '{
        rf: '0,
        staging: 8'h00,
        sp: SP_RESET,
        status_flags: crf_pkg::STATUS_RESET,
        guard: crf_pkg::GUARD_OFF,
        cnt: 3'h0,
        rdata: 8'h00,
        pend: '0
    };

    crf_state_t st_reg;
    crf_state_t st_next;
    logic [4:0] ptr_lo;
    logic [4:0] ptr_hi;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic ptr_upd;
    logic [4:0] wr_dst;
    logic sig_wr;
    logic close_io;
    logic close_spm;

    // Working register reads are straight from the array, no wait state
    // direct access
    assign o_rf_rdata_a = st_reg.rf[i_rf_raddr_a];
    assign o_rf_rdata_b = st_reg.rf[i_rf_raddr_b];

    // Immediate-class writes have the top address bit forced high
    // upper half
    assign wr_dst = i_rf_imm ? {1'b1, i_rf_waddr[3:0]} : i_rf_waddr;

    // Pointer pair select; select code 3 is unused and leaves the file alone
    // pair mapping
    assign ptr_lo = crf_pkg::PTR_BASE + {2'b00, i_ptr_req.sel, 1'b0};
    assign ptr_hi = ptr_lo + 5'h01;
    assign ptr_val = {st_reg.rf[ptr_hi], st_reg.rf[ptr_lo]};

    // Address generation per load/store variant
    // addressing variants
    always_comb begin
        ptr_new = ptr_val;
        ptr_upd = 1'b0;
        o_ptr_addr = ptr_val;
        case (i_ptr_req.mode)
            crf_pkg::PTR_DISP: begin
                o_ptr_addr = ptr_val + {10'h000, i_ptr_req.disp};
            end
            crf_pkg::PTR_POSTINC: begin
                ptr_new = ptr_val + 16'h0001;
                ptr_upd = (i_ptr_req.sel != 2'b11);
            end
            crf_pkg::PTR_PREDEC: begin
                ptr_new = ptr_val - 16'h0001;
                o_ptr_addr = ptr_new;
                ptr_upd = (i_ptr_req.sel != 2'b11);
            end
            default: begin
                o_ptr_addr = ptr_val;
            end
        endcase
    end

    // Third pair doubles as the program memory pointer
    // program pointer
    assign o_prog_ptr = {st_reg.rf[5'h1F], st_reg.rf[5'h1E]};

    // A valid signature written to the guard opens a window
    // signature decode
    assign sig_wr = i_bus.wr && (i_bus.addr == crf_pkg::GUARD_OFS)
        && ((i_bus.wdata == crf_pkg::SIG_IO) || (i_bus.wdata == crf_pkg::SIG_SPM));

    // Any bus write that is not a signature counts as an I/O write
    // close events
    assign close_io = i_evt.mem_write || (i_bus.wr && !sig_wr) || i_evt.nvm_access || i_evt.sleep;
    assign close_spm = i_evt.nvm_access || i_evt.sleep;

    // Next-state logic for the whole block
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 8'h00;
        // Pointer update goes first so an explicit register write wins
        if (ptr_upd) begin
            st_next.rf[ptr_lo] = ptr_new[7:0];
            st_next.rf[ptr_hi] = ptr_new[15:8];
        end
        if (i_rf_we) begin
            st_next.rf[wr_dst] = i_rf_wdata;
        end
        // One staging byte serves both directions; an interleaved wide access corrupts it
        // staged write
        if (i_bus.wr) begin
            case (i_bus.addr)
                crf_pkg::SP_LOW_OFS: st_next.staging = i_bus.wdata;
                crf_pkg::SP_HIGH_OFS: st_next.sp = {i_bus.wdata, st_reg.staging};
                crf_pkg::STATUS_OFS: st_next.status_flags = i_bus.wdata;
                default: st_next.status_flags = st_reg.status_flags;
            endcase
        end
        if (i_bus.rd) begin
            case (i_bus.addr)
                crf_pkg::GUARD_OFS: begin
                    st_next.rdata = {6'h00, st_reg.guard == crf_pkg::GUARD_SPM,
                        st_reg.guard == crf_pkg::GUARD_IO};
                end
                crf_pkg::SP_LOW_OFS: begin
                    st_next.rdata = st_reg.sp[7:0];
                    st_next.staging = st_reg.sp[15:8];
                end
                crf_pkg::SP_HIGH_OFS: st_next.rdata = st_reg.staging;
                crf_pkg::STATUS_OFS: st_next.rdata = st_reg.status_flags;
                default: st_next.rdata = 8'h00;
            endcase
        end
        // Window closes early on an event, else after four executed instructions
        // window end
        case (st_reg.guard)
            crf_pkg::GUARD_IO, crf_pkg::GUARD_SPM: begin
                if ((st_reg.guard == crf_pkg::GUARD_IO) ? close_io : close_spm) begin
                    st_next.guard = crf_pkg::GUARD_OFF;
                end else if (i_evt.instr_done) begin
                    if (st_reg.cnt == crf_pkg::WINDOW_INSTRS - 3'h1) begin
                        st_next.guard = crf_pkg::GUARD_OFF;
                    end else begin
                        st_next.cnt = st_reg.cnt + 3'h1;
                    end
                end
            end
            default: st_next.guard = crf_pkg::GUARD_OFF;
        endcase
        // A signature restarts the window; the writing instruction is not counted
        // window open
        if (sig_wr) begin
            st_next.cnt = 3'h0;
            st_next.guard = (i_bus.wdata == crf_pkg::SIG_IO) ? crf_pkg::GUARD_IO : crf_pkg::GUARD_SPM;
        end
        // Requests latch even inside a window; a new request beats its ack
        // pending hold
        st_next.pend = (st_reg.pend & ~i_irq_ack) | i_irq_req;
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Unlock outputs come straight from the guard state
    // unlock gating
    assign o_io_unlocked = (st_reg.guard == crf_pkg::GUARD_IO);
    assign o_spm_unlocked = (st_reg.guard == crf_pkg::GUARD_SPM);

    // Interrupts are held off, not dropped, while a window is open
    // interrupt gate
    assign o_irq_take = (|st_reg.pend) && (st_reg.guard == crf_pkg::GUARD_OFF);
    assign o_irq_pending = st_reg.pend;
    assign o_reg_rdata = st_reg.rdata;
    assign o_stack_ptr = st_reg.sp;
    assign o_status = st_reg.status_flags;

    // Checks on the block's own behaviour
    default clocking crf_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    imm_upper_a: assert property (i_rf_we && i_rf_imm |=>
        st_reg.rf[{1'b1, $past(i_rf_waddr[3:0])}] == $past(i_rf_wdata))
        else $error("Immediate write missed upper half");

    sig_open_a: assert property (i_bus.wr && i_bus.addr == crf_pkg::GUARD_OFS
        && i_bus.wdata == crf_pkg::SIG_IO |=> o_io_unlocked && st_reg.cnt == 3'h0)
        else $error("I/O signature did not open window");

    bad_sig_a: assert property (i_bus.wr && !sig_wr && !o_io_unlocked && !o_spm_unlocked
        |=> !o_io_unlocked && !o_spm_unlocked)
        else $error("Window opened without signature");

    guard_read_a: assert property (i_bus.rd && i_bus.addr == crf_pkg::GUARD_OFS
        |=> o_reg_rdata == {6'h00, $past(o_spm_unlocked), $past(o_io_unlocked)})
        else $error("Guard readback wrong");

    count_end_a: assert property (st_reg.guard != crf_pkg::GUARD_OFF && i_evt.instr_done
        && st_reg.cnt == 3'h3 && !sig_wr |=> st_reg.guard == crf_pkg::GUARD_OFF)
        else $error("Window outlived four instructions");

    io_close_a: assert property (o_io_unlocked && i_evt.mem_write && !sig_wr
        |=> !o_io_unlocked)
        else $error("I/O window not closed by write");

    spm_close_a: assert property (o_spm_unlocked && (i_evt.nvm_access || i_evt.sleep) && !sig_wr
        |=> !o_spm_unlocked)
        else $error("Self-program window not closed");

    irq_block_a: assert property (o_io_unlocked || o_spm_unlocked |-> !o_irq_take)
        else $error("Interrupt taken inside window");

    irq_hold_a: assert property (i_irq_req[0] |=> o_irq_pending[0]
        && (o_irq_take || o_io_unlocked || o_spm_unlocked))
        else $error("Request not held pending");

    low_write_a: assert property (i_bus.wr && i_bus.addr == crf_pkg::SP_LOW_OFS
        |=> o_stack_ptr == $past(o_stack_ptr))
        else $error("Low byte write changed register");

    high_write_a: assert property (i_bus.wr && i_bus.addr == crf_pkg::SP_LOW_OFS
        ##1 i_bus.wr && i_bus.addr == crf_pkg::SP_HIGH_OFS
        |=> o_stack_ptr == {$past(i_bus.wdata), $past(i_bus.wdata, 2)})
        else $error("Paired write not atomic");

    pair_read_a: assert property (i_bus.rd && i_bus.addr == crf_pkg::SP_LOW_OFS
        ##1 i_bus.rd && i_bus.addr == crf_pkg::SP_HIGH_OFS
        |=> o_reg_rdata == $past(o_stack_ptr[15:8], 2))
        else $error("High byte not from staging");

    ptr_inc_a: assert property (i_ptr_req.mode == crf_pkg::PTR_POSTINC && i_ptr_req.sel == 2'b10
        && !i_rf_we |=> o_prog_ptr == $past(o_prog_ptr) + 16'h0001)
        else $error("Post-increment failed");

    // Further checks on register file, staging byte, window and interrupt hold

    rf_write_a: assert property (i_rf_we && !i_rf_imm |=>
        st_reg.rf[$past(i_rf_waddr)] == $past(i_rf_wdata))
        else $error("Register write lost");

    rf_hold_a: assert property (!i_rf_we && (i_ptr_req.sel == 2'b11
        || i_ptr_req.mode == crf_pkg::PTR_NONE || i_ptr_req.mode == crf_pkg::PTR_DISP)
        |=> st_reg.rf == $past(st_reg.rf))
        else $error("Register file changed without a write");

    imm_low_a: assert property (i_rf_we && i_rf_imm |=>
        st_reg.rf[15:0] == $past(st_reg.rf[15:0]))
        else $error("Immediate write reached lower half");

    ptr_dec_a: assert property (i_ptr_req.sel == 2'b10 && i_ptr_req.mode == crf_pkg::PTR_PREDEC && !i_rf_we
        |=> {st_reg.rf[5'h1F], st_reg.rf[5'h1E]} == $past({st_reg.rf[5'h1F], st_reg.rf[5'h1E]}) - 16'h0001)
        else $error("Pre-decrement failed");

    ptr_map_a: assert property (i_ptr_req.sel == 2'b01 && i_ptr_req.mode == crf_pkg::PTR_POSTINC
        |-> o_ptr_addr == {st_reg.rf[5'h1D], st_reg.rf[5'h1C]})
        else $error("Pointer byte order wrong");

    ptr_disp_a: assert property (i_ptr_req.sel == 2'b00 && i_ptr_req.mode == crf_pkg::PTR_DISP
        |-> o_ptr_addr == {st_reg.rf[5'h1B], st_reg.rf[5'h1A]} + {10'h000, i_ptr_req.disp})
        else $error("Displacement address wrong");

    stage_wr_a: assert property (i_bus.wr && i_bus.addr == crf_pkg::SP_LOW_OFS
        |=> st_reg.staging == $past(i_bus.wdata))
        else $error("Low byte write missed staging");

    sp_hold_a: assert property (!(i_bus.wr && i_bus.addr == crf_pkg::SP_HIGH_OFS)
        |=> o_stack_ptr == $past(o_stack_ptr))
        else $error("Stack pointer changed without high write");

    low_read_a: assert property (i_bus.rd && i_bus.addr == crf_pkg::SP_LOW_OFS
        |=> o_reg_rdata == $past(o_stack_ptr[7:0]) && st_reg.staging == $past(o_stack_ptr[15:8]))
        else $error("Low byte read wrong");

    high_read_a: assert property (i_bus.rd && i_bus.addr == crf_pkg::SP_HIGH_OFS
        |=> o_reg_rdata == $past(st_reg.staging))
        else $error("High byte read not from staging");

    spm_open_a: assert property (i_bus.wr && i_bus.addr == crf_pkg::GUARD_OFS
        && i_bus.wdata == crf_pkg::SIG_SPM |=> o_spm_unlocked && !o_io_unlocked)
        else $error("Self-program signature did not open window");

    bus_close_a: assert property (o_io_unlocked && i_bus.wr && i_bus.addr != crf_pkg::GUARD_OFS
        |=> !o_io_unlocked)
        else $error("I/O window not closed by bus write");

    io_nvm_a: assert property (o_io_unlocked && (i_evt.nvm_access || i_evt.sleep) && !sig_wr
        |=> !o_io_unlocked)
        else $error("I/O window not closed by access or sleep");

    spm_keep_a: assert property (o_spm_unlocked && !i_evt.nvm_access && !i_evt.sleep
        && !i_evt.instr_done && !sig_wr |=> o_spm_unlocked)
        else $error("Self-program window closed early");

    pend_keep_a: assert property (o_irq_pending[0] && !i_irq_ack[0] |=> o_irq_pending[0])
        else $error("Pending request dropped");

    pend_ack_a: assert property (i_irq_ack[0] && !i_irq_req[0] |=> !o_irq_pending[0])
        else $error("Acknowledged request still pending");

    win_take_a: assert property (o_io_unlocked && i_evt.instr_done && st_reg.cnt == 3'h3 && !sig_wr
        && o_irq_pending[0] && !i_irq_ack[0] |=> o_irq_take)
        else $error("Held request not taken after window");

    cnt_limit_a: assert property (o_io_unlocked || o_spm_unlocked |-> st_reg.cnt < crf_pkg::WINDOW_INSTRS)
        else $error("Window counter out of range");

    cnt_hold_a: assert property ((o_io_unlocked || o_spm_unlocked) && !i_evt.instr_done && !i_bus.wr
        |=> st_reg.cnt == $past(st_reg.cnt))
        else $error("Window counted a cycle without an instruction");

    io_win_c: cover property (sig_wr && i_bus.wdata == crf_pkg::SIG_IO ##1 i_evt.mem_write);
    spm_win_c: cover property (sig_wr && i_bus.wdata == crf_pkg::SIG_SPM ##1 i_evt.nvm_access);
    held_irq_c: cover property (o_io_unlocked && i_irq_req[0] ##[1:16] o_irq_take);
    pair_rd_c: cover property (i_bus.rd && i_bus.addr == crf_pkg::SP_LOW_OFS
        ##1 i_bus.rd && i_bus.addr == crf_pkg::SP_HIGH_OFS);
    win_end_c: cover property (o_io_unlocked ##1 (!o_io_unlocked && o_irq_take));

endmodule : crf_core

// file: tb/crf_cpu_model.sv
`timescale 1ns/1ns
module crf_cpu_model (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_run,
    input wire logic i_slow,
    input wire logic [2:0] i_side,
    output crf_pkg::crf_cpu_evt_t o_evt
);
    logic phase_reg;
    // Retire pulses; slow mode stands for two-cycle instructions
    // side events issued one cycle late
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_reg <= 1'b0;
            o_evt <= '0;
        end else begin
            phase_reg <= i_slow ? ~phase_reg : 1'b1;
            o_evt.instr_done <= i_run && (!i_slow || phase_reg);
            o_evt.mem_write <= i_side[2];
            o_evt.nvm_access <= i_side[1];
            o_evt.sleep <= i_side[0];
        end
    end
endmodule : crf_cpu_model

// file: tb/test_crf_core.sv
`timescale 1ns/1ns
module test_crf_core;
    logic clk, rstn, we, imm, run, slow;
    logic [4:0] ra, rb, wa;
    logic [7:0] wd, ra_d, rb_d, rdata, st, irq, ack, pend;
    logic [15:0] pa, pp, sp;
    logic [2:0] side;
    logic io, self_program_unlock, take;
    int bad_count, samples_checked, n_done, n0, k;
    crf_pkg::crf_ptr_req_t preq;
    crf_pkg::crf_bus_req_t bus;
    crf_pkg::crf_cpu_evt_t evt;
    crf_core dut_u (.i_ref_clk(clk), .i_resetn(rstn), .i_rf_raddr_a(ra), .i_rf_raddr_b(rb),
        .o_rf_rdata_a(ra_d), .o_rf_rdata_b(rb_d), .i_rf_we(we), .i_rf_imm(imm), .i_rf_waddr(wa),
        .i_rf_wdata(wd), .i_ptr_req(preq), .o_ptr_addr(pa), .o_prog_ptr(pp), .i_bus(bus),
        .o_reg_rdata(rdata), .i_evt(evt), .o_io_unlocked(io), .o_spm_unlocked(self_program_unlock),
        .i_irq_req(irq), .i_irq_ack(ack), .o_irq_pending(pend), .o_irq_take(take),
        .o_stack_ptr(sp), .o_status(st));
    crf_cpu_model cpu_u (.i_ref_clk(clk), .i_resetn(rstn), .i_run(run), .i_slow(slow),
        .i_side(side), .o_evt(evt));
    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Retired instruction count seen at the design edge
    always @(posedge clk) n_done <= n_done + int'(evt.instr_done);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    // Bus cycles leave one idle cycle so no strobe is assigned twice in a step
    task wr(input logic [5:0] a, input logic [7:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask : wr
    task rd(input logic [5:0] a, input logic [7:0] exp);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        bus <= '0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
        @(posedge clk);
    endtask : rd
    // Back-to-back wide write with no idle cycle between the bytes
    task wr2(input logic [15:0] d);
        bus <= '{1'b1, 1'b0, 6'h0D, d[7:0]};
        @(posedge clk);
        bus <= '{1'b1, 1'b0, 6'h0E, d[15:8]};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask : wr2
    // Back-to-back wide read: low byte first, then high byte from staging
    task rd2(input logic [15:0] e);
        bus <= '{1'b0, 1'b1, 6'h0D, 8'h00};
        @(posedge clk);
        bus <= '{1'b0, 1'b1, 6'h0E, 8'h00};
        #1 chk({8'h00, rdata}, {8'h00, e[7:0]});
        @(posedge clk);
        bus <= '0;
        #1 chk({8'h00, rdata}, {8'h00, e[15:8]});
        @(posedge clk);
    endtask : rd2
    task rfw(input logic [4:0] a, input logic [7:0] d, input logic i);
        we <= 1'b1;
        wa <= a;
        wd <= d;
        imm <= i;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
    endtask : rfw
    task ptr(input logic [1:0] s, input crf_pkg::crf_ptr_mode_t m, input logic [5:0] d, input logic [15:0] e);
        preq <= '{s, m, d};
        #1 chk(pa, e);
        @(posedge clk);
        preq <= '{2'd3, crf_pkg::PTR_NONE, 6'h00};
        @(posedge clk);
    endtask : ptr
    task ev(input logic [2:0] s);
        side <= s;
        @(posedge clk);
        side <= 3'b000;
        repeat (2) @(posedge clk);
        #1;
    endtask : ev
    initial begin
        {we, imm, run, slow, ra, rb, wa, wd, irq, ack, side} = '0;
        bus = '0;
        preq = '{2'd3, crf_pkg::PTR_NONE, 6'h00};
        {bad_count, samples_checked, n_done} = '0;
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(6'h0F, 8'h00);
        rd(6'h04, 8'h00);
        rd(6'h07, 8'h00);
        rd(6'h0D, 8'hFF);
        rd(6'h0E, 8'hFF);
        wr(6'h0D, 8'h34);
        chk(sp, 16'hFFFF);
        wr(6'h0E, 8'h12);
        chk(sp, 16'h1234);
        rd(6'h0D, 8'h34);
        rd(6'h0E, 8'h12);
        wr2(16'hBEEF);
        chk(sp, 16'hBEEF);
        rd2(16'hBEEF);
        $display("test wide access done");
        for (k = 0; k < 32; k++) rfw(k[4:0], 8'h10 + 8'(k), 1'b0);
        rfw(5'h05, 8'hC3, 1'b1);
        ra <= 5'h05;
        rb <= 5'h15;
        #1 chk({ra_d, rb_d}, 16'h15C3);
        chk(pp, 16'h2F2E);
        ptr(2'd0, crf_pkg::PTR_DISP, 6'h3F, 16'h2B69);
        ptr(2'd1, crf_pkg::PTR_POSTINC, 6'h00, 16'h2D2C);
        ptr(2'd1, crf_pkg::PTR_DISP, 6'h00, 16'h2D2D);
        ptr(2'd2, crf_pkg::PTR_PREDEC, 6'h00, 16'h2F2D);
        chk(pp, 16'h2F2D);
        ptr(2'd2, crf_pkg::PTR_POSTINC, 6'h00, 16'h2F2D);
        chk(pp, 16'h2F2E);
        $display("test register file done");
        wr(6'h04, 8'h55);
        chk({io, self_program_unlock}, 2'b00);
        wr(6'h04, 8'h9D);
        rd(6'h04, 8'h02);
        ev(3'b100);
        chk(self_program_unlock, 1'b1);
        ev(3'b010);
        chk(self_program_unlock, 1'b0);
        wr(6'h04, 8'hD8);
        rd(6'h04, 8'h01);
        ev(3'b001);
        chk(io, 1'b0);
        wr(6'h04, 8'hD8);
        ev(3'b100);
        chk(io, 1'b0);
        wr(6'h04, 8'hD8);
        wr(6'h0F, 8'hA5);
        chk(io, 1'b0);
        chk(st, 8'hA5);
        wr(6'h04, 8'hD8);
        irq <= 8'h01;
        @(posedge clk);
        irq <= 8'h00;
        n0 <= n_done;
        run <= 1'b1;
        slow <= 1'b1;
        #1 chk({pend, 7'h00, take}, 16'h0100);
        for (k = 0; k < 30 && io === 1'b1; k++) @(posedge clk) #1;
        if (k == 30) begin
            bad_count++;
            $display("MISMATCH %0t window never closed", $time);
        end
        chk(16'(n_done - n0), 16'h0004);
        chk(take, 1'b1);
        run <= 1'b0;
        ack <= 8'h01;
        @(posedge clk);
        ack <= 8'h00;
        #1 chk({pend, 7'h00, take}, 16'h0000);
        $display("test change guard done");
        summarize();
    end
endmodule : test_crf_core
